// *** hdl/mpl_latch.sv ***
// Mark position latch with window check and interrupt positioning load
//
// How it works
// - Function select 0 runs the latch; 1 runs interrupt positioning.
// - Capture position on a mark edge only inside the plus/minus window.
// - Equal limits make the whole range valid.
// - Linear units latch only when upper is not below lower, for either command method.
// - Linear units raise the parameter alarm when upper is below lower.
// - Digit halves of differing sign give a negative limit.
// - Roll feed off compares limits with position from home.
// - Roll feed on compares limits with travel from the start position.
// - Degree limits are kept within 0 to 359.999 degrees.
// - Degree limits outside the span are folded modulo 360 into it.
// - Degree window wraps through zero when lower exceeds upper.
// - Position capture completes within 0.4 ms of the mark event.
// - Rising done flag clears as falling done flag sets.
// - Edge outside the window leaves latched data unchanged.
// - Rise after an out-of-window fall updates data, not the rising flag.
// - Interrupt mode loads remaining travel with the mark stop distance.
// - Interrupt ignored in home return, manual, standstill, temporary stop.
// - Current position is captured when the mark input turns on.
// - Latch suppressed during home return and manual operation.
//
// Decided for this implementation: the register addresses and strobed register access.
`timescale 1ns/1ps
module mpl_latch #(
  parameter int LATCH_CYC = mpl_pkg::LATCH_CYC
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [3:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  input wire logic mark_detect_input,
  input wire logic temp_stop_resume_input,
  input wire logic signed [31:0] position,
  input wire logic move_start,
  input wire logic home_return_active,
  input wire logic manual_active,
  input wire logic motion_active,
  output logic rise_latch_done_flag,
  output logic fall_latch_done_flag,
  output logic parameter_error_alarm,
  output logic remain_load,
  output logic signed [31:0] remain_dist
);
  logic [6:0] ctrl_r;
  logic signed [15:0] plus_lo_r, plus_hi_r, minus_lo_r, minus_hi_r;
  logic signed [31:0] stop_dist_r, rise_data_r, fall_data_r, start_r;
  logic [31:0] rdata_r;
  logic mark_s1_r, mark_s2_r, mark_s3_r, mark_stab_r, mark_prev_r;
  logic temp_stop_resume_input_s1_r, temp_stop_resume_input_s2_r, temp_stop_resume_input_s3_r, temp_stop_resume_input_stab_r;
  logic rise_flag_r, fall_flag_r, fall_out_r, alarm_r, intr_active_r;
  logic remain_load_r;
  logic signed [31:0] remain_dist_r;
  logic signed [31:0] plus_v, minus_v, pos_ref;
  logic rise_ev, fall_ev, in_win, latch_ok, intr_ok, degree, roll;

  // ==========================================================
  // Helpers
  function automatic logic signed [31:0] norm_deg(input logic signed [31:0] v);
    logic signed [31:0] r;
    r = v % mpl_pkg::DEG_SPAN;
    if (r < 0)
    begin
      r = r + mpl_pkg::DEG_SPAN;
    end
    return r;
  endfunction
  // ==========================================================
  // Register writes
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      ctrl_r <= mpl_pkg::CTRL_RST;
      plus_lo_r <= mpl_pkg::DIGIT_RST;
      plus_hi_r <= mpl_pkg::DIGIT_RST;
      minus_lo_r <= mpl_pkg::DIGIT_RST;
      minus_hi_r <= mpl_pkg::DIGIT_RST;
      stop_dist_r <= mpl_pkg::WORD_RST;
    end
    else if (wr)
    begin
      unique case (addr)
        mpl_pkg::REG_CTRL: ctrl_r <= wdata[6:0];
        mpl_pkg::REG_PLUS_LO: plus_lo_r <= wdata[15:0];
        mpl_pkg::REG_PLUS_HI: plus_hi_r <= wdata[15:0];
        mpl_pkg::REG_MINUS_LO: minus_lo_r <= wdata[15:0];
        mpl_pkg::REG_MINUS_HI: minus_hi_r <= wdata[15:0];
        mpl_pkg::REG_STOP_DIST: stop_dist_r <= wdata;
        default: ;
      endcase
    end
  end
  // ==========================================================
  // Register reads, data one cycle after the strobe
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      rdata_r <= mpl_pkg::WORD_RST;
    end
    else if (rd)
    begin
      unique case (addr)
        mpl_pkg::REG_CTRL: rdata_r <= {25'h0, ctrl_r};
        mpl_pkg::REG_PLUS_LO: rdata_r <= {{16{plus_lo_r[15]}}, plus_lo_r};
        mpl_pkg::REG_PLUS_HI: rdata_r <= {{16{plus_hi_r[15]}}, plus_hi_r};
        mpl_pkg::REG_MINUS_LO: rdata_r <= {{16{minus_lo_r[15]}}, minus_lo_r};
        mpl_pkg::REG_MINUS_HI: rdata_r <= {{16{minus_hi_r[15]}}, minus_hi_r};
        mpl_pkg::REG_STOP_DIST: rdata_r <= stop_dist_r;
        mpl_pkg::REG_STATUS: rdata_r <= {27'h0, intr_active_r, in_win, alarm_r, fall_flag_r, rise_flag_r};
        mpl_pkg::REG_RISE_DATA: rdata_r <= rise_data_r;
        mpl_pkg::REG_FALL_DATA: rdata_r <= fall_data_r;
        default: rdata_r <= mpl_pkg::WORD_RST;
      endcase
    end
    else
    begin
      rdata_r <= mpl_pkg::WORD_RST;
    end
  end
  // ==========================================================
  // Pin synchronisers; a change is taken when stages two and three agree
  // short capture path
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      {mark_s1_r, mark_s2_r, mark_s3_r, mark_stab_r, mark_prev_r} <= 5'h00;
      {temp_stop_resume_input_s1_r, temp_stop_resume_input_s2_r, temp_stop_resume_input_s3_r, temp_stop_resume_input_stab_r} <= 4'h0;
    end
    else
    begin
      mark_s1_r <= mark_detect_input;
      mark_s2_r <= mark_s1_r;
      mark_s3_r <= mark_s2_r;
      if (mark_s2_r == mark_s3_r)
      begin
        mark_stab_r <= mark_s3_r;
      end
      mark_prev_r <= mark_stab_r;
      temp_stop_resume_input_s1_r <= temp_stop_resume_input;
      temp_stop_resume_input_s2_r <= temp_stop_resume_input_s1_r;
      temp_stop_resume_input_s3_r <= temp_stop_resume_input_s2_r;
      if (temp_stop_resume_input_s2_r == temp_stop_resume_input_s3_r)
      begin
        temp_stop_resume_input_stab_r <= temp_stop_resume_input_s3_r;
      end
    end
  end
  assign rise_ev = mark_stab_r & ~mark_prev_r;
  assign fall_ev = ~mark_stab_r & mark_prev_r;
  // ==========================================================
  // Window limits
  mpl_limit_conv u_plus (
    .low_digits(plus_lo_r),
    .high_digits(plus_hi_r),
    .degree_unit(degree),
    .limit_value(plus_v)
  );
  mpl_limit_conv u_minus (
    .low_digits(minus_lo_r),
    .high_digits(minus_hi_r),
    .degree_unit(degree),
    .limit_value(minus_v)
  );
  assign degree = ctrl_r[mpl_pkg::CTRL_DEGREE];
  assign roll = ctrl_r[mpl_pkg::CTRL_ROLL];
  // Start position for roll feed travel
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      start_r <= mpl_pkg::WORD_RST;
    end
    else if (move_start)
    begin
      start_r <= position;
    end
  end
  always_comb
  begin
    pos_ref = position;
    if (roll)
    begin
      pos_ref = position - start_r;
    end
    if (degree)
    begin
      pos_ref = norm_deg(pos_ref);
    end
    if (plus_v == minus_v)
    begin
      in_win = 1'b1;
    end
    else if (!degree)
    begin
      in_win = (plus_v > minus_v) && (pos_ref >= minus_v) && (pos_ref <= plus_v);
    end
    else if (plus_v > minus_v)
    begin
      in_win = (pos_ref >= minus_v) && (pos_ref <= plus_v);
    end
    else
    begin
      in_win = (pos_ref >= minus_v) || (pos_ref <= plus_v);
    end
  end
  assign latch_ok = !ctrl_r[mpl_pkg::CTRL_MARK_FN] && !home_return_active && !manual_active;
  assign intr_ok = ctrl_r[mpl_pkg::CTRL_MARK_FN] && !home_return_active && !manual_active
                   && motion_active && !temp_stop_resume_input_stab_r && !intr_active_r;
  // ==========================================================
  // Position latch and done flags
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      rise_data_r <= mpl_pkg::WORD_RST;
      fall_data_r <= mpl_pkg::WORD_RST;
      rise_flag_r <= 1'b0;
      fall_flag_r <= 1'b0;
      fall_out_r <= 1'b0;
    end
    else if (rise_ev && latch_ok && in_win)
    begin
      rise_data_r <= pos_ref;
      if (!fall_out_r)
      begin
        rise_flag_r <= 1'b1;
        fall_flag_r <= 1'b0;
      end
    end
    else if (fall_ev && latch_ok)
    begin
      fall_out_r <= !in_win;
      if (in_win)
      begin
        fall_data_r <= pos_ref;
        fall_flag_r <= 1'b1;
        rise_flag_r <= 1'b0;
      end
    end
  end
  // ==========================================================
  // Parameter alarm, held until reset
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      alarm_r <= 1'b0;
    end
    else if (!degree && plus_v < minus_v)
    begin
      alarm_r <= 1'b1;
    end
  end
  // ==========================================================
  // Interrupt positioning
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      intr_active_r <= 1'b0;
      remain_load_r <= 1'b0;
      remain_dist_r <= mpl_pkg::WORD_RST;
    end
    else
    begin
      remain_load_r <= 1'b0;
      if (!motion_active)
      begin
        intr_active_r <= 1'b0;
      end
      if (rise_ev && intr_ok)
      begin
        intr_active_r <= 1'b1;
        remain_load_r <= 1'b1;
        remain_dist_r <= stop_dist_r;
      end
    end
  end
  assign rdata = rdata_r;
  assign rise_latch_done_flag = rise_flag_r;
  assign fall_latch_done_flag = fall_flag_r;
  assign parameter_error_alarm = alarm_r;
  assign remain_load = remain_load_r;
  assign remain_dist = remain_dist_r;

  // ==========================================================
  // Checks
  logic [15:0] lat_cnt_r;
  always_ff @(posedge mclk)
  begin
    if (rst || (mark_s3_r == mark_prev_r))
    begin
      lat_cnt_r <= 16'h0000;
    end
    else
    begin
      lat_cnt_r <= lat_cnt_r + 16'h0001;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  mode_sel_a: assert property (ctrl_r[mpl_pkg::CTRL_MARK_FN] && $past(ctrl_r[mpl_pkg::CTRL_MARK_FN]) |-> !$rose(rise_flag_r)) else $error("flag set in interrupt mode");
  window_cap_a: assert property ($changed(rise_data_r) |-> $past(rise_ev && in_win && latch_ok)) else $error("capture outside window");
  whole_range_a: assert property (rise_ev && latch_ok && plus_v == minus_v |=> rise_data_r == $past(pos_ref)) else $error("equal limits not whole range");
  lin_order_a: assert property (!degree && plus_v < minus_v |-> !in_win) else $error("inverted window accepted");
  param_alarm_a: assert property (!degree && plus_v < minus_v |=> parameter_error_alarm) else $error("alarm missing");
  deg_span_a: assert property (degree |-> plus_v >= 0 && plus_v < mpl_pkg::DEG_SPAN && minus_v >= 0) else $error("degree limit out of span");
  latch_time_a: assert property (lat_cnt_r < 16'(LATCH_CYC)) else $error("capture too slow");
  flag_swap_a: assert property ($rose(fall_flag_r) |-> !rise_latch_done_flag) else $error("rise flag not cleared");
  keep_data_a: assert property (fall_ev && !in_win |=> $stable(fall_data_r)) else $error("data changed outside window");
  rerise_a: assert property (rise_ev && latch_ok && in_win && fall_out_r |=> $stable(rise_flag_r) && rise_data_r == $past(pos_ref)) else $error("rerise wrong");
  stop_load_a: assert property (remain_load |-> remain_dist == stop_dist_r ##1 !remain_load) else $error("stop distance wrong");
  intr_ignore_a: assert property (rise_ev && (home_return_active || manual_active || !motion_active || temp_stop_resume_input_stab_r) |=> !remain_load) else $error("interrupt not ignored");
  suppress_a: assert property (rise_ev && (home_return_active || manual_active) |=> $stable(rise_data_r)) else $error("latch not suppressed");
endmodule

// *** hdl/mpl_pkg.sv ***
// Constants for the mark position latch window block
package mpl_pkg;
  // Clock and latch timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int LATCH_TIME_NS = 400000;
  localparam int LATCH_CYC = LATCH_TIME_NS / CLK_PERIOD_NS;
  // Digit split and degree span, in thousandths
  localparam int DIGIT_SCALE = 1000;
  localparam logic signed [31:0] DEG_SPAN = 32'sh0005_7E40;
  // Register offsets (word index)
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_PLUS_LO = 4'h1;
  localparam logic [3:0] REG_PLUS_HI = 4'h2;
  localparam logic [3:0] REG_MINUS_LO = 4'h3;
  localparam logic [3:0] REG_MINUS_HI = 4'h4;
  localparam logic [3:0] REG_STOP_DIST = 4'h5;
  localparam logic [3:0] REG_STATUS = 4'h6;
  localparam logic [3:0] REG_RISE_DATA = 4'h7;
  localparam logic [3:0] REG_FALL_DATA = 4'h8;
  // Control field positions
  localparam int CTRL_MARK_FN = 0;
  localparam int CTRL_ROLL = 1;
  localparam int CTRL_DEGREE = 2;
  localparam int CTRL_CMD_METHOD = 3;
  localparam int CTRL_FAST_PIN = 4;
  localparam int CTRL_FILTER_LSB = 5;
  localparam int CTRL_WIDTH = 7;
  // Status field positions
  localparam int STAT_RISE = 0;
  localparam int STAT_FALL = 1;
  localparam int STAT_ALARM = 2;
  localparam int STAT_IN_WIN = 3;
  localparam int STAT_INTR = 4;
  // Reset values
  localparam logic [6:0] CTRL_RST = 7'h00;
  localparam logic [15:0] DIGIT_RST = 16'h0000;
  localparam logic [31:0] WORD_RST = 32'h0000_0000;
endpackage

// *** hdl/mpl_limit_conv.sv ***
// Combines one pair of window limit digit halves into a single limit value
`timescale 1ns/1ps
module mpl_limit_conv (
  input wire logic signed [15:0] low_digits,
  input wire logic signed [15:0] high_digits,
  input wire logic degree_unit,
  output logic signed [31:0] limit_value
);
  logic signed [31:0] mag;
  logic signed [31:0] lin;
  logic signed [31:0] rem;
  logic neg;

  always_comb
  begin
    neg = low_digits[15] | high_digits[15];
    mag = 32'(high_digits[15] ? -high_digits : high_digits) * mpl_pkg::DIGIT_SCALE
        + 32'(low_digits[15] ? -low_digits : low_digits);
    lin = neg ? -mag : mag;
    rem = lin % mpl_pkg::DEG_SPAN;
    if (rem < 0)
    begin
      rem = rem + mpl_pkg::DEG_SPAN;
    end
    limit_value = degree_unit ? rem : lin;
  end
endmodule

// *** tb/mpl_mark_sensor.sv ***
// Mark sensor model driving the mark pin away from the sampling edge
`timescale 1ns/1ps
module mpl_mark_sensor (
  input wire logic mclk,
  input wire logic want,
  output logic mark_detect_input
);
  // ==========
  // Pin update
  // Changes land on the falling edge, half a cycle away from the block's sampling edge
  always @(negedge mclk)
  begin
    mark_detect_input <= want;
  end
endmodule

// *** tb/testbench.sv ***
// Self-checking bench for the mark position latch window block
`timescale 1ns/1ps
module testbench;
  localparam int LT = 20;
  logic mclk, rst, wr, rd, want, tstop, move_start, home, manual, motion;
  logic [3:0] addr;
  logic [31:0] wdata, rdata, rdist, seen_dist;
  logic signed [31:0] position;
  logic mark, rflag, fflag, alarm, rload;
  int errors, compares, loads;

  // ==========
  // Instances
  mpl_mark_sensor sensor (.mclk(mclk), .want(want), .mark_detect_input(mark));
  mpl_latch #(.LATCH_CYC(LT)) dut (.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .mark_detect_input(mark), .temp_stop_resume_input(tstop), .position(position),
    .move_start(move_start), .home_return_active(home), .manual_active(manual), .motion_active(motion),
    .rise_latch_done_flag(rflag), .fall_latch_done_flag(fflag), .parameter_error_alarm(alarm),
    .remain_load(rload), .remain_dist(rdist));

  // ==========
  // Clock and load monitor
  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  always @(posedge mclk)
  begin
    if (rload === 1'b1)
    begin
      loads <= loads + 1;
      seen_dist <= rdist;
    end
  end

  // ==========
  // Tasks
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      errors++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp, input string name);
    @(posedge mclk);
    rd <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    check(name, exp, rdata);
  endtask
  // Drives one mark edge at a position, then checks both done flags
  task automatic edge_chk(input logic lvl, input logic [31:0] pos, input logic er, input logic ef);
    @(posedge mclk);
    position <= pos;
    want <= lvl;
    repeat (LT) @(posedge mclk);
    #1;
    check("rise flag", {31'h0, er}, {31'h0, rflag});
    check("fall flag", {31'h0, ef}, {31'h0, fflag});
  endtask
  task automatic tally_and_finish;
    $display("Comparisons %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
    begin
      $display("Regression OK");
    end
    else
    begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ==========
  // Watchdog
  initial
  begin
    repeat (30000) @(posedge mclk);
    errors++;
    tally_and_finish;
  end

  // ==========
  // Main sequence
  initial
  begin
    {rst, wr, rd, want, tstop, move_start, home, manual, motion} = 9'h100;
    addr = 4'h0;
    wdata = 32'h0;
    position = 32'sh0;
    errors = 0;
    compares = 0;
    loads = 0;
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    wr_reg(mpl_pkg::REG_RISE_DATA, 32'h0000_1234);
    rd_chk(mpl_pkg::REG_STATUS, 32'h0000_0008, "status");
    rd_chk(mpl_pkg::REG_RISE_DATA, 32'h0, "rise data");
    rd_chk(4'hF, 32'h0, "unmapped");
    // Linear window: plus 500.000, minus halves of differing sign
    wr_reg(mpl_pkg::REG_PLUS_HI, 32'h0000_01F4);
    wr_reg(mpl_pkg::REG_MINUS_LO, 32'hFFFF_FE0C);
    wr_reg(mpl_pkg::REG_MINUS_HI, 32'h0000_00C8);
    edge_chk(1'b1, 32'h0006_1A80, 1'b1, 1'b0);
    rd_chk(mpl_pkg::REG_RISE_DATA, 32'h0006_1A80, "rise data");
    edge_chk(1'b0, 32'h0006_DDD0, 1'b0, 1'b1);
    rd_chk(mpl_pkg::REG_FALL_DATA, 32'h0006_DDD0, "fall data");
    edge_chk(1'b1, 32'h0009_27C0, 1'b0, 1'b1);
    rd_chk(mpl_pkg::REG_RISE_DATA, 32'h0006_1A80, "rise data");
    edge_chk(1'b0, 32'hFFFC_EED8, 1'b0, 1'b1);
    rd_chk(mpl_pkg::REG_FALL_DATA, 32'h0006_DDD0, "fall data");
    edge_chk(1'b1, 32'hFFFC_F2C0, 1'b0, 1'b1);
    rd_chk(mpl_pkg::REG_RISE_DATA, 32'hFFFC_F2C0, "rise data");
    edge_chk(1'b0, 32'h0006_1A80, 1'b0, 1'b1);
    rd_chk(mpl_pkg::REG_FALL_DATA, 32'h0006_1A80, "fall data");
    check("alarm", 32'h0, {31'h0, alarm});
    // Equal limits open the whole range; minus moved high half first
    wr_reg(mpl_pkg::REG_PLUS_HI, 32'h0);
    wr_reg(mpl_pkg::REG_MINUS_HI, 32'h0);
    wr_reg(mpl_pkg::REG_MINUS_LO, 32'h0);
    edge_chk(1'b1, 32'h000D_BBA0, 1'b1, 1'b0);
    edge_chk(1'b0, 32'hFFF2_4460, 1'b0, 1'b1);
    rd_chk(mpl_pkg::REG_FALL_DATA, 32'hFFF2_4460, "fall data");
    // Roll feed: window 300.000 to 500.000 of travel from a start at 100.000
    wr_reg(mpl_pkg::REG_CTRL, 32'h2);
    rd_chk(mpl_pkg::REG_CTRL, 32'h2, "ctrl");
    wr_reg(mpl_pkg::REG_PLUS_HI, 32'h0000_01F4);
    wr_reg(mpl_pkg::REG_MINUS_HI, 32'h0000_012C);
    @(posedge mclk);
    position <= 32'sh0001_86A0;
    move_start <= 1'b1;
    @(posedge mclk);
    move_start <= 1'b0;
    edge_chk(1'b1, 32'h0006_DDD0, 1'b1, 1'b0);
    rd_chk(mpl_pkg::REG_RISE_DATA, 32'h0005_5730, "rise data");
    edge_chk(1'b0, 32'h0008_6470, 1'b0, 1'b1);
    wr_reg(mpl_pkg::REG_CTRL, 32'h0000_0078);
    rd_chk(mpl_pkg::REG_CTRL, 32'h0000_0078, "ctrl");
    edge_chk(1'b1, 32'h0006_DDD0, 1'b1, 1'b0);
    rd_chk(mpl_pkg::REG_RISE_DATA, 32'h0006_DDD0, "rise data");
    // Home return and manual operation suppress the latch
    @(posedge mclk);
    home <= 1'b1;
    edge_chk(1'b0, 32'h0006_1A80, 1'b1, 1'b0);
    home <= 1'b0;
    manual <= 1'b1;
    edge_chk(1'b1, 32'h0006_1A80, 1'b1, 1'b0);
    edge_chk(1'b0, 32'h0006_68A0, 1'b1, 1'b0);
    manual <= 1'b0;
    rd_chk(mpl_pkg::REG_FALL_DATA, 32'h0006_DDD0, "fall data");
    edge_chk(1'b1, 32'h0006_1A80, 1'b1, 1'b0);
    edge_chk(1'b0, 32'h0006_1A80, 1'b0, 1'b1);
    // Degree units: 450 folds to 90, -45 folds to 315, arc wraps through zero
    wr_reg(mpl_pkg::REG_CTRL, 32'h4);
    wr_reg(mpl_pkg::REG_PLUS_HI, 32'h0000_01C2);
    wr_reg(mpl_pkg::REG_MINUS_HI, 32'hFFFF_FFD3);
    edge_chk(1'b1, 32'h0000_2710, 1'b1, 1'b0);
    rd_chk(mpl_pkg::REG_RISE_DATA, 32'h0000_2710, "rise data");
    edge_chk(1'b0, 32'h0002_BF20, 1'b1, 1'b0);
    edge_chk(1'b1, 32'h0005_0910, 1'b1, 1'b0);
    rd_chk(mpl_pkg::REG_RISE_DATA, 32'h0005_0910, "rise data");
    edge_chk(1'b0, 32'h0005_3020, 1'b0, 1'b1);
    check("alarm", 32'h0, {31'h0, alarm});
    // Interrupt positioning: standstill and temporary stop ignore the mark
    wr_reg(mpl_pkg::REG_CTRL, 32'h1);
    wr_reg(mpl_pkg::REG_STOP_DIST, 32'h0000_3039);
    edge_chk(1'b1, 32'h0001_86A0, 1'b0, 1'b1);
    edge_chk(1'b0, 32'h0001_86A0, 1'b0, 1'b1);
    tstop <= 1'b1;
    motion <= 1'b1;
    edge_chk(1'b1, 32'h0001_86A0, 1'b0, 1'b1);
    tstop <= 1'b0;
    edge_chk(1'b0, 32'h0001_86A0, 1'b0, 1'b1);
    check("loads", 32'h0, 32'(loads));
    edge_chk(1'b1, 32'h0001_86A0, 1'b0, 1'b1);
    check("loads", 32'h1, 32'(loads));
    check("remain dist", 32'h0000_3039, seen_dist);
    edge_chk(1'b0, 32'h0001_86A0, 1'b0, 1'b1);
    motion <= 1'b0;
    rd_chk(mpl_pkg::REG_RISE_DATA, 32'h0005_0910, "rise data");
    // Upper limit below lower limit in linear units
    wr_reg(mpl_pkg::REG_CTRL, 32'h0);
    wr_reg(mpl_pkg::REG_PLUS_HI, 32'h0000_0064);
    wr_reg(mpl_pkg::REG_MINUS_HI, 32'h0000_012C);
    repeat (4) @(posedge mclk);
    #1;
    check("alarm", 32'h1, {31'h0, alarm});
    @(posedge mclk);
    rst <= 1'b1;
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    #1;
    check("alarm", 32'h0, {31'h0, alarm});
    rd_chk(mpl_pkg::REG_STATUS, 32'h0000_0008, "status");
    tally_and_finish;
  end
endmodule
